// [rtl/msg_framer_map.svh]
// constants for the ascii serial message framer
// Functional notes
// - plain frames (error correction off, polled or not): '#', data, end characters; no sequence or check.
// - error-correcting frames carry one hex sequence digit after '#', even in own messages.
// - sequence advances only on a valid acknowledge; otherwise keep resending.
// - outgoing data field is at most 72 characters.
// - four hex check digits hold a 16-bit crc over characters after '#'.
// - outgoing data messages end in carriage return then line feed.
// - acknowledge with a different sequence digit causes a resend.
// - acknowledge timer starts on each send; value FF disables it.
// - acknowledge marks delivery, bumps sequence, advances the queue.
// - host code 01 requests command mode, plain or error-correcting.
// - polled mode: one buffered message sent per received 0x05.
// - responses to error-correcting commands echo the sequence digit of the last accepted command.
// - command repeating the previous sequence digit is not run; old answer resent.
// - command code two to four hex characters, data at most 20.
// - receive timer from '#'; expiry without end discards the partial message.
// - command with non-hex sequence digit is dropped silently.
// - parity bit of each character is part of the crc.
`ifndef MSG_FRAMER_MAP_SVH
`define MSG_FRAMER_MAP_SVH
`define SOM_CHAR      8'h23
`define POLL_CHAR     8'h05
`define CR_CHAR       8'h0D
`define LF_CHAR       8'h0A
`define ACK_CHAR      8'h40
`define NAK_CHAR      8'h3F
`define TMO_OFF       8'hFF
`define CMD_MODE_CODE 16'h3031
`define SEQ_STEP      4'h2
`define MAX_DATA      72
`define CMD_MIN_LEN   5'h02
`define CMD_MAX_LEN   5'h18
`define CRC_POLY      16'h1021
`define CRC_INIT      16'h0000
`define CLK_NS        100
`define ACK_TICK_US   10000
`define ACK_TICK_CYC  (`ACK_TICK_US * 1000 / `CLK_NS)
`define RX_TMO_US     100000
`define RX_TMO_CYC    (`RX_TMO_US * 1000 / `CLK_NS)
`endif

// [rtl/msg_framer_pkg.sv]
// types for the ascii serial message framer
package msg_framer_pkg;
    typedef enum logic [2:0] {
        F_IDLE = 3'h0, F_SOM = 3'h1, F_SEQ = 3'h3, F_DATA = 3'h2,
        F_CRC  = 3'h6, F_CR  = 3'h7, F_LF  = 3'h5, F_WAIT = 3'h4
    } tx_field_e;

    typedef struct packed {
        tx_field_e   field;
        logic        sending;
        logic [6:0]  idx;
        logic [6:0]  len;
        logic        resp;
        logic [7:0]  tx_char;
        logic [15:0] tx_crc;
        logic [3:0]  seq;
        logic [31:0] tick;
        logic [7:0]  ticks;
        logic [7:0]  credit;
        logic        rx_active;
        logic        rx_need_seq;
        logic [3:0]  rx_seq;
        logic        rx_bad_seq;
        logic [31:0] win;
        logic [2:0]  wcnt;
        logic [15:0] rx_crc;
        logic [4:0]  blen;
        logic [15:0] head;
        logic [31:0] rx_tmr;
        logic [3:0]  last_seq;
        logic        have_last;
        logic        msg_done;
        logic        cmd_char_valid;
        logic [7:0]  cmd_char;
        logic        cmd_done;
        logic        cmd_ok;
        logic        cmd_repeat;
        logic        cmd_mode_req;
    } state_s;
endpackage : msg_framer_pkg

// [rtl/msg_framer.sv]
// ascii serial message framer, acknowledge engine and command parser
`timescale 1ns/1ns
`default_nettype none
`include "msg_framer_map.svh"
module msg_framer #(
    parameter int unsigned MAX_DATA        = `MAX_DATA,
    parameter logic [15:0] CRC_POLY        = `CRC_POLY,
    parameter logic [15:0] CRC_INIT        = `CRC_INIT,
    parameter int unsigned ACK_TICK_CYCLES = `ACK_TICK_CYC,
    parameter int unsigned RX_TMO_CYCLES   = `RX_TMO_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_ecp,
    input  wire logic       i_poll_mode,
    input  wire logic [7:0] i_ack_timeout,
    input  wire logic       i_msg_valid,
    input  wire logic       i_msg_resp,
    input  wire logic [6:0] i_msg_len,
    input  wire logic [7:0] i_msg_char,
    output logic [6:0]      o_msg_idx,
    output logic            o_msg_done,
    output logic            o_tx_valid,
    output logic [7:0]      o_tx_char,
    input  wire logic       i_tx_ready,
    input  wire logic       i_rx_valid,
    input  wire logic [7:0] i_rx_char,
    output logic            o_cmd_char_valid,
    output logic [7:0]      o_cmd_char,
    output logic            o_cmd_done,
    output logic            o_cmd_ok,
    output logic            o_cmd_repeat,
    output logic            o_cmd_mode_req,
    output logic            o_wait_ack
);
    // ==========================================================
    // elaboration checks
    if (MAX_DATA < 1 || MAX_DATA > 127) begin : g_bad_max
        $error("MAX_DATA must be 1..127");
    end
    if (ACK_TICK_CYCLES < 1 || RX_TMO_CYCLES < 1) begin : g_bad_tmo
        $error("timeout counts must be at least 1");
    end

    // ==========================================================
    // helpers
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] x;
        x = c;
        for (int i = 7; i >= 0; i--) begin
            if (x[15] ^ b[i]) begin
                x = {x[14:0], 1'b0} ^ CRC_POLY;
            end else begin
                x = {x[14:0], 1'b0};
            end
        end
        return x;
    endfunction : crc_byte

    // {valid, value}
    function automatic logic [4:0] hex_val(input logic [7:0] ch);
        if (ch >= 8'h30 && ch <= 8'h39) begin
            return {1'b1, ch[3:0]};
        end else if (ch >= 8'h41 && ch <= 8'h46) begin
            return {1'b1, 4'(ch[3:0] + 4'h9)};
        end else begin
            return 5'h00;
        end
    endfunction : hex_val

    function automatic logic [7:0] hex_char(input logic [3:0] n);
        return (n < 4'hA) ? {4'h3, n} : {4'h4, 4'(n - 4'h9)};
    endfunction : hex_char

    // ==========================================================
    // state
    msg_framer_pkg::state_s r_reg;
    msg_framer_pkg::state_s r_next;
    logic        emit;
    logic [7:0]  ech;
    logic        finish;
    logic        crc_ok;
    logic        is_ack;
    logic        ack_ok;
    logic        ack_bad;
    logic        t_expire;
    logic [15:0] rx_got;
    logic [4:0]  h0;
    logic [4:0]  h1;
    logic [4:0]  h2;
    logic [4:0]  h3;
    logic [3:0]  nib;
    logic [4:0]  hv;

    always_comb begin
        r_next = r_reg;
        r_next.msg_done = 1'b0;
        r_next.cmd_char_valid = 1'b0;
        r_next.cmd_done = 1'b0;
        r_next.cmd_repeat = 1'b0;
        r_next.cmd_mode_req = 1'b0;
        emit = 1'b0;
        ech = 8'h00;
        finish = 1'b0;
        ack_ok = 1'b0;
        ack_bad = 1'b0;
        t_expire = 1'b0;
        nib = 4'h0;
        hv = hex_val(i_rx_char);
        // ======================================================
        // receive side
        // receive timer aborts stale frames
        if (r_reg.rx_active) begin
            r_next.rx_tmr = r_reg.rx_tmr + 32'h1;
            if (r_reg.rx_tmr == RX_TMO_CYCLES - 1) begin
                r_next.rx_active = 1'b0;
            end
        end
        if (i_rx_valid) begin
            if (i_poll_mode && !r_reg.rx_active && i_rx_char == `POLL_CHAR) begin
                if (r_reg.credit != 8'hFF) begin
                    r_next.credit = r_reg.credit + 8'h01;
                end
            end else if (i_rx_char == `SOM_CHAR) begin
                r_next.rx_active = 1'b1;
                r_next.rx_need_seq = i_ecp;
                r_next.rx_bad_seq = 1'b0;
                r_next.rx_tmr = 32'h0;
                r_next.wcnt = 3'h0;
                r_next.blen = 5'h00;
                r_next.head = 16'h0000;
                r_next.rx_crc = CRC_INIT;
            end else if (r_reg.rx_active && i_rx_char == `CR_CHAR) begin
                r_next.rx_active = 1'b0;
                finish = 1'b1;
            end else if (r_reg.rx_active && r_reg.rx_need_seq) begin
                r_next.rx_seq = hv[3:0];
                r_next.rx_bad_seq = !hv[4];
                r_next.rx_need_seq = 1'b0;
                r_next.rx_crc = crc_byte(r_reg.rx_crc, i_rx_char);
            end else if (r_reg.rx_active) begin
                if (i_ecp) begin
                    // last four characters may be the check field
                    r_next.win = {r_reg.win[23:0], i_rx_char};
                    if (r_reg.wcnt == 3'h4) begin
                        emit = 1'b1;
                        ech = r_reg.win[31:24];
                    end else begin
                        r_next.wcnt = r_reg.wcnt + 3'h1;
                    end
                end else begin
                    emit = 1'b1;
                    ech = i_rx_char;
                end
            end
        end
        if (emit) begin
            r_next.rx_crc = crc_byte(r_reg.rx_crc, ech);
            r_next.cmd_char_valid = 1'b1;
            r_next.cmd_char = ech;
            if (r_reg.blen != 5'h1F) begin
                r_next.blen = r_reg.blen + 5'h01;
            end
            if (r_reg.blen == 5'h00) begin
                r_next.head[15:8] = ech;
            end else if (r_reg.blen == 5'h01) begin
                r_next.head[7:0] = ech;
            end
        end
        h0 = hex_val(r_reg.win[31:24]);
        h1 = hex_val(r_reg.win[23:16]);
        h2 = hex_val(r_reg.win[15:8]);
        h3 = hex_val(r_reg.win[7:0]);
        rx_got = {h0[3:0], h1[3:0], h2[3:0], h3[3:0]};
        crc_ok = !i_ecp || (r_reg.wcnt == 3'h4 && h0[4] && h1[4] && h2[4] && h3[4]
                 && rx_got == r_reg.rx_crc);
        is_ack = i_ecp && r_reg.blen == 5'h01
                 && (r_reg.head[15:8] == `ACK_CHAR || r_reg.head[15:8] == `NAK_CHAR);
        if (finish) begin
            if (is_ack) begin
                if (r_reg.field == msg_framer_pkg::F_WAIT) begin
                    // wrong or illegal sequence, bad crc or nak resend
                    if (crc_ok && !r_reg.rx_bad_seq && !r_reg.rx_need_seq
                        && r_reg.rx_seq == r_reg.seq && r_reg.head[15:8] == `ACK_CHAR) begin
                        ack_ok = 1'b1;
                    end else begin
                        ack_bad = 1'b1;
                    end
                end
            end else if (i_ecp && (r_reg.rx_bad_seq || r_reg.rx_need_seq)) begin
                r_next.cmd_done = 1'b0;
            end else if (i_ecp && crc_ok && r_reg.have_last && r_reg.rx_seq == r_reg.last_seq) begin
                r_next.cmd_repeat = 1'b1;
            end else begin
                r_next.cmd_done = 1'b1;
                r_next.cmd_ok = crc_ok && r_reg.blen >= `CMD_MIN_LEN
                                && r_reg.blen <= `CMD_MAX_LEN;
                if (r_next.cmd_ok && i_ecp) begin
                    r_next.last_seq = r_reg.rx_seq;
                    r_next.have_last = 1'b1;
                end
                r_next.cmd_mode_req = r_next.cmd_ok && r_reg.blen == 5'h02
                                      && r_reg.head == `CMD_MODE_CODE;
            end
        end
        // ======================================================
        // transmit side
        unique case (r_reg.field)
            msg_framer_pkg::F_IDLE: begin
                if (i_msg_valid && (i_msg_resp || !i_poll_mode || r_next.credit != 8'h00)) begin
                    r_next.field = msg_framer_pkg::F_SOM;
                    r_next.sending = 1'b0;
                    r_next.resp = i_msg_resp;
                    r_next.len = (i_msg_len > 7'(MAX_DATA)) ? 7'(MAX_DATA) : i_msg_len;
                    if (i_poll_mode && !i_msg_resp) begin
                        r_next.credit = r_next.credit - 8'h01;
                    end
                end
            end
            msg_framer_pkg::F_WAIT: begin
                if (i_ack_timeout != `TMO_OFF) begin
                    r_next.tick = r_reg.tick + 32'h1;
                    if (r_reg.tick == ACK_TICK_CYCLES - 1) begin
                        r_next.tick = 32'h0;
                        r_next.ticks = r_reg.ticks + 8'h01;
                        t_expire = (r_reg.ticks + 8'h01) >= i_ack_timeout;
                    end
                end
                if (ack_ok) begin
                    r_next.msg_done = 1'b1;
                    r_next.seq = r_reg.seq + `SEQ_STEP;
                    r_next.field = msg_framer_pkg::F_IDLE;
                end else if (ack_bad || t_expire) begin
                    r_next.field = msg_framer_pkg::F_SOM;
                    r_next.sending = 1'b0;
                end
            end
            default: begin
                if (!r_reg.sending) begin
                    r_next.sending = 1'b1;
                    unique case (r_reg.field)
                        msg_framer_pkg::F_SOM: begin
                            r_next.tx_char = `SOM_CHAR;
                            r_next.tx_crc = CRC_INIT;
                            r_next.idx = 7'h00;
                        end
                        msg_framer_pkg::F_SEQ: begin
                            // even own digit, or command echo
                            r_next.tx_char = hex_char(r_reg.resp ? r_reg.last_seq : r_reg.seq);
                            r_next.tx_crc = crc_byte(r_reg.tx_crc, r_next.tx_char);
                        end
                        msg_framer_pkg::F_DATA: begin
                            r_next.tx_char = i_msg_char;
                            r_next.tx_crc = crc_byte(r_reg.tx_crc, i_msg_char);
                        end
                        msg_framer_pkg::F_CRC: begin
                            nib = 4'(r_reg.tx_crc >> {r_reg.idx[1:0] ^ 2'h3, 2'h0});
                            r_next.tx_char = hex_char(nib);
                        end
                        msg_framer_pkg::F_CR: r_next.tx_char = `CR_CHAR;
                        default: r_next.tx_char = `LF_CHAR;
                    endcase
                end else if (i_tx_ready) begin
                    r_next.sending = 1'b0;
                    unique case (r_reg.field)
                        msg_framer_pkg::F_SOM, msg_framer_pkg::F_SEQ: begin
                            // plain frames skip sequence and check
                            if (i_ecp && r_reg.field == msg_framer_pkg::F_SOM) begin
                                r_next.field = msg_framer_pkg::F_SEQ;
                            end else if (r_reg.len != 7'h00) begin
                                r_next.field = msg_framer_pkg::F_DATA;
                            end else begin
                                r_next.field = i_ecp ? msg_framer_pkg::F_CRC
                                                     : msg_framer_pkg::F_CR;
                            end
                        end
                        msg_framer_pkg::F_DATA: begin
                            r_next.idx = r_reg.idx + 7'h01;
                            if (r_reg.idx + 7'h01 == r_reg.len) begin
                                r_next.idx = 7'h00;
                                r_next.field = i_ecp ? msg_framer_pkg::F_CRC
                                                     : msg_framer_pkg::F_CR;
                            end
                        end
                        msg_framer_pkg::F_CRC: begin
                            r_next.idx = r_reg.idx + 7'h01;
                            if (r_reg.idx == 7'h03) begin
                                r_next.idx = 7'h00;
                                r_next.field = msg_framer_pkg::F_CR;
                            end
                        end
                        msg_framer_pkg::F_CR: r_next.field = msg_framer_pkg::F_LF;
                        default: begin
                            if (i_ecp && !r_reg.resp) begin
                                r_next.field = msg_framer_pkg::F_WAIT;
                                r_next.tick = 32'h0;
                                r_next.ticks = 8'h00;
                            end else begin
                                r_next.field = msg_framer_pkg::F_IDLE;
                                r_next.msg_done = 1'b1;
                            end
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_msg_idx        = r_reg.idx;
    assign o_msg_done       = r_reg.msg_done;
    assign o_tx_valid       = r_reg.sending;
    assign o_tx_char        = r_reg.tx_char;
    assign o_cmd_char_valid = r_reg.cmd_char_valid;
    assign o_cmd_char       = r_reg.cmd_char;
    assign o_cmd_done       = r_reg.cmd_done;
    assign o_cmd_ok         = r_reg.cmd_ok;
    assign o_cmd_repeat     = r_reg.cmd_repeat;
    assign o_cmd_mode_req   = r_reg.cmd_mode_req;
    assign o_wait_ack       = r_reg.field == msg_framer_pkg::F_WAIT;

    // ==========================================================
    // checks
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_som; o_tx_valid && r_reg.field == msg_framer_pkg::F_SOM |-> o_tx_char == `SOM_CHAR; endproperty
    a_som: assert property (p_som) else $error("start character wrong");
    property p_even; o_tx_valid && r_reg.field == msg_framer_pkg::F_SEQ && !r_reg.resp
        |-> !r_reg.seq[0] && o_tx_char == hex_char(r_reg.seq); endproperty
    a_even: assert property (p_even) else $error("odd reader sequence");
    property p_seq_adv; r_reg.seq != $past(r_reg.seq) |-> o_msg_done
        && $past(r_reg.field) == msg_framer_pkg::F_WAIT; endproperty
    a_seq_adv: assert property (p_seq_adv) else $error("sequence moved without ack");
    property p_len; r_reg.field != msg_framer_pkg::F_IDLE |-> r_reg.len <= 7'(MAX_DATA); endproperty
    a_len: assert property (p_len) else $error("data too long");
    property p_crlf; o_tx_valid && i_tx_ready && r_reg.field == msg_framer_pkg::F_CR
        |-> ##2 o_tx_valid && o_tx_char == `LF_CHAR; endproperty
    a_crlf: assert property (p_crlf) else $error("line feed missing");
    property p_resend; r_reg.field == msg_framer_pkg::F_WAIT && (ack_bad || t_expire)
        |=> r_reg.field == msg_framer_pkg::F_SOM && !o_tx_valid ##1 o_tx_valid; endproperty
    a_resend: assert property (p_resend) else $error("no resend");
    property p_tmo_off; r_reg.field == msg_framer_pkg::F_WAIT && i_ack_timeout == `TMO_OFF
        && !finish |=> r_reg.field == msg_framer_pkg::F_WAIT; endproperty
    a_tmo_off: assert property (p_tmo_off) else $error("timeout while disabled");
    property p_ack; ack_ok |=> o_msg_done && r_reg.field == msg_framer_pkg::F_IDLE
        && r_reg.seq == $past(r_reg.seq) + `SEQ_STEP; endproperty
    a_ack: assert property (p_ack) else $error("ack not honoured");
    property p_repeat; o_cmd_repeat |-> !o_cmd_done && !o_cmd_mode_req; endproperty
    a_repeat: assert property (p_repeat) else $error("repeated command run");
    property p_badseq; finish && i_ecp && !is_ack && r_reg.rx_bad_seq
        |=> !o_cmd_done && !o_cmd_repeat; endproperty
    a_badseq: assert property (p_badseq) else $error("illegal sequence answered");
endmodule : msg_framer
`default_nettype wire

// [dv/host_model.sv]
// host side model: collects reader chars and sends host frames
`timescale 1ns/1ns
`default_nettype none
`include "msg_framer_map.svh"
module host_model (
    input  wire logic       i_clk,
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_char,
    output logic            o_tx_ready,
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_char
);
    logic [7:0] got_q[$];
    logic       slow;
    initial begin
        slow = 1'b0;
        o_tx_ready = 1'b0;
        o_rx_valid = 1'b0;
        o_rx_char = 8'hFF;
    end
    // stall every other cycle when slow
    always @(posedge i_clk) begin
        // a new start drops any partial frame
        if (i_tx_valid === 1'b1 && o_tx_ready === 1'b1 && i_tx_char == `SOM_CHAR) got_q.delete();
        if (i_tx_valid === 1'b1 && o_tx_ready === 1'b1) got_q.push_back(i_tx_char);
        #1 o_tx_ready = slow ? ~o_tx_ready : 1'b1;
    end
    function automatic logic [7:0] hexc(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
    endfunction : hexc
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? `CRC_POLY : 16'h0);
        return c;
    endfunction : crc_step
    // released line shows the inverse char
    task automatic send_char(input logic [7:0] c);
        @(posedge i_clk);
        #1 o_rx_valid = 1'b1;
        o_rx_char = c;
        @(posedge i_clk);
        #1 o_rx_valid = 1'b0;
        o_rx_char = ~c;
    endtask : send_char
    task automatic send_frame(input logic [7:0] body[$]);
        logic [15:0] c;
        c = `CRC_INIT;
        send_char(`SOM_CHAR);
        foreach (body[i]) begin
            send_char(body[i]);
            c = crc_step(c, body[i]);
        end
        for (int i = 3; i >= 0; i--) send_char(hexc(c[4*i+:4]));
        send_char(`CR_CHAR);
    endtask : send_frame
endmodule : host_model
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the message framer
`timescale 1ns/1ns
`default_nettype none
`include "msg_framer_map.svh"
module testbench;
    logic       i_clk, i_rst, i_ecp, i_msg_valid, o_msg_done, o_tx_valid, tx_ready, rx_valid;
    logic       o_cmd_done, o_cmd_ok, o_cmd_repeat, o_cmd_mode_req, o_wait_ack;
    logic [7:0] i_ack_timeout, o_tx_char, rx_char;
    logic [6:0] i_msg_len, o_msg_idx;
    logic       cd, ok, md, rp, dn, i_poll_mode, i_msg_resp;
    int         fails, tests_run, cyc;
    msg_framer #(.ACK_TICK_CYCLES(4), .RX_TMO_CYCLES(200)) u_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_ecp(i_ecp), .i_poll_mode(i_poll_mode),
        .i_ack_timeout(i_ack_timeout), .i_msg_valid(i_msg_valid), .i_msg_resp(i_msg_resp),
        .i_msg_len(i_msg_len), .i_msg_char(8'h41 + {1'b0, o_msg_idx}),
        .o_msg_idx(o_msg_idx), .o_msg_done(o_msg_done), .o_tx_valid(o_tx_valid),
        .o_tx_char(o_tx_char), .i_tx_ready(tx_ready), .i_rx_valid(rx_valid),
        .i_rx_char(rx_char), .o_cmd_char_valid(), .o_cmd_char(), .o_cmd_done(o_cmd_done),
        .o_cmd_ok(o_cmd_ok), .o_cmd_repeat(o_cmd_repeat), .o_cmd_mode_req(o_cmd_mode_req),
        .o_wait_ack(o_wait_ack));
    host_model u_host (.i_clk(i_clk), .i_tx_valid(o_tx_valid), .i_tx_char(o_tx_char),
        .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_char(rx_char));
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    task automatic check(input logic c, input string m);
        tests_run++;
        if (c !== 1'b1) begin
            fails++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask : check
    // expected reader frame compared char by char
    task automatic check_frame(input logic [3:0] s, input logic e, input logic [6:0] n);
        logic [7:0]  q[$];
        logic [15:0] c;
        int          k;
        c = `CRC_INIT;
        k = 0;
        if (e) q.push_back(u_host.hexc(s));
        for (int i = 0; i < n; i++) q.push_back(8'h41 + i);
        foreach (q[i]) c = u_host.crc_step(c, q[i]);
        if (e) for (int i = 3; i >= 0; i--) q.push_back(u_host.hexc(c[4*i+:4]));
        q.push_front(`SOM_CHAR);
        q.push_back(`CR_CHAR);
        q.push_back(`LF_CHAR);
        while (u_host.got_q.size() < q.size() && k < 2000) begin
            @(posedge i_clk);
            #1 k++;
        end
        @(posedge i_clk);
        #1 check(u_host.got_q.size() == q.size(), "frame length");
        foreach (q[i]) check(u_host.got_q.pop_front() === q[i], "frame char");
        u_host.got_q.delete();
    endtask : check_frame
    task automatic wait_done();
        int k;
        k = 0;
        while (dn !== 1'b1 && k < 300) begin
            @(posedge i_clk);
            #1 k++;
        end
        check(dn, "no delivery pulse");
        dn = 1'b0;
        i_msg_valid = 1'b0;
    endtask : wait_done
    task automatic start_msg(input logic [6:0] n);
        i_msg_len = n;
        i_msg_valid = 1'b1;
        @(posedge i_clk);
        #1 i_msg_valid = 1'b0;
    endtask : start_msg
    task automatic run_cmd(input logic [7:0] b[$]);
        {cd, ok, md, rp} = 4'h0;
        u_host.send_frame(b);
        repeat (4) @(posedge i_clk);
        #1;
    endtask : run_cmd
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (o_cmd_done === 1'b1) {cd, ok, md} <= {1'b1, o_cmd_ok, o_cmd_mode_req};
        if (o_cmd_repeat === 1'b1) rp <= 1'b1;
        if (o_msg_done === 1'b1) dn <= 1'b1;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    initial begin
        {i_rst, i_ecp, i_msg_valid, cd, ok, md, rp, dn, i_poll_mode, i_msg_resp} = 10'h200;
        {i_ack_timeout, i_msg_len, fails, tests_run, cyc} = '0;
        repeat (8) @(posedge i_clk);
        #1 i_rst = 1'b0;
        start_msg(7'h03);
        check_frame(4'h0, 1'b0, 7'h03);
        wait_done();
        $display("plain test ended");
        {i_ecp, i_ack_timeout, u_host.slow} = {1'b1, 8'hFF, 1'b1};
        for (int s = 0; s < 4; s += 2) begin
            start_msg(7'h02);
            check_frame(4'(s), 1'b1, 7'h02);
            check(o_wait_ack, "not waiting for ack");
            u_host.send_frame('{u_host.hexc(4'(s)), `ACK_CHAR});
            wait_done();
        end
        u_host.slow = 1'b0;
        $display("ack test ended");
        start_msg(7'h01);
        check_frame(4'h4, 1'b1, 7'h01);
        u_host.send_frame('{8'h34, `NAK_CHAR});
        check_frame(4'h4, 1'b1, 7'h01);
        u_host.send_frame('{8'h36, `ACK_CHAR});
        check_frame(4'h4, 1'b1, 7'h01);
        i_ack_timeout = 8'h02;
        check_frame(4'h4, 1'b1, 7'h01);
        i_ack_timeout = 8'hFF;
        repeat (100) @(posedge i_clk);
        check(u_host.got_q.size() == 0, "resent with timer off");
        u_host.send_frame('{8'h34, `ACK_CHAR});
        wait_done();
        $display("retry test ended");
        run_cmd('{8'h31, 8'h30, 8'h31});
        check(cd && ok && md, "no mode request");
        run_cmd('{8'h31, 8'h30, 8'h31});
        check(rp, "repeat not flagged");
        run_cmd('{8'h47, 8'h30, 8'h31});
        check(!cd && !rp, "bad sequence served");
        run_cmd('{8'h33, 8'h30});
        check(cd && !ok, "short code accepted");
        i_msg_resp = 1'b1;
        start_msg(7'h02);
        check_frame(4'h1, 1'b1, 7'h02);
        wait_done();
        i_msg_resp = 1'b0;
        $display("command test ended");
        {i_ecp, i_poll_mode} = 2'b01;
        u_host.send_char(`POLL_CHAR);
        start_msg(7'h7F);
        check_frame(4'h0, 1'b0, 7'(`MAX_DATA));
        wait_done();
        start_msg(7'h01);
        repeat (40) @(posedge i_clk);
        #1 check(u_host.got_q.size() == 0, "sent without poll");
        $display("poll test ended");
        summarize();
    end
endmodule : testbench
`default_nettype wire
